// [inc/pio_pkg.sv]
// Package of constants, codes and carriers for the programmable I/O function select block
// Behaviour
// R1 - Restore reloads factory values, keeps currents and connection type
// R2 - Fault relay code 1 closes contact without fault
// R3 - Fault relay code 2 closes contact on fault
// R4 - Operation mode: on at switch-on, off at switch-off or ramp at 30%
// R5 - Full-voltage mode: on at 100%, off at switch-off or ramp-down
// R6 - Direction mode: relay one follows input three
// R7 - Reversal needs input three code 4, relay one code 3, standard connection
// R8 - Full-voltage relay driving bypass needs bypass enable; bypass_enable is only stored and read back, it gates no relay
// R9 - Relay two codes 1-2 as relay one; code 3 brakes on off command
// R10 - No DC braking in inside-delta connection
// R11 - Input code 1 clears error status on each rise to 24 V
// R12 - Input code 2 raises external error while open
// R13 - Input code 3 is general enable; firing suppressed while open
// R14 - Input two code 4: three-wire, start input starts, input two stops
// R15 - Inputs accept OFF or codes 1-4; defaults 1, 2, OFF
// R16 - Input three code 4 high drives relay one to reverse
// R17 - Input four code 4 high applies jog voltage
// R18 - Analog output is 8 bits; OFF default disables it
// R19 - Analog source codes: current, voltage, power factor, thermal state
// R20 - Relays offer codes 1-3; defaults 1 for relay one, 2 for relay two
// R21 - With several general enables, first to open is emergency stop
// R22 - Every digital input is synchronised before decoding
package pio_pkg;

    // ==========================================================
    // Function codes
    localparam logic [2:0] PIO_OFF       = 3'h0;
    localparam logic [2:0] PIO_CODE_1    = 3'h1;
    localparam logic [2:0] PIO_CODE_2    = 3'h2;
    localparam logic [2:0] PIO_CODE_3    = 3'h3;
    localparam logic [2:0] PIO_CODE_4    = 3'h4;

    // ==========================================================
    // Factory values
    localparam logic [2:0] PIO_RST_FAULT_FN  = 3'h1;
    localparam logic [2:0] PIO_RST_RELAY1_FN = 3'h1;
    localparam logic [2:0] PIO_RST_RELAY2_FN = 3'h2;
    localparam logic [2:0] PIO_RST_IN2_FN    = 3'h1;
    localparam logic [2:0] PIO_RST_IN3_FN    = 3'h2;
    localparam logic [2:0] PIO_RST_IN4_FN    = 3'h0;
    localparam logic [2:0] PIO_RST_ANA_SEL   = 3'h0;
    localparam logic [9:0] PIO_RST_ANA_GAIN  = 10'h064;  // 1.00 in hundredths
    localparam logic [7:0] PIO_RST_JOG       = 8'h00;
    localparam logic [7:0] PIO_RST_CURRENT   = 8'h00;

    // ==========================================================
    // Voltage thresholds in percent of rated voltage
    localparam logic [7:0] PIO_PCT_LOW  = 8'h1E;  // 30 %
    localparam logic [7:0] PIO_PCT_FULL = 8'h64;  // 100 %

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] PIO_ADR_FAULT_FN  = 8'h00;
    localparam logic [7:0] PIO_ADR_RELAY1_FN = 8'h04;
    localparam logic [7:0] PIO_ADR_RELAY2_FN = 8'h08;
    localparam logic [7:0] PIO_ADR_IN2_FN    = 8'h0C;
    localparam logic [7:0] PIO_ADR_IN3_FN    = 8'h10;
    localparam logic [7:0] PIO_ADR_IN4_FN    = 8'h14;
    localparam logic [7:0] PIO_ADR_ANA_SEL   = 8'h18;
    localparam logic [7:0] PIO_ADR_ANA_GAIN  = 8'h1C;
    localparam logic [7:0] PIO_ADR_MISC      = 8'h20;
    localparam logic [7:0] PIO_ADR_JOG       = 8'h24;
    localparam logic [7:0] PIO_ADR_CUR_A     = 8'h28;
    localparam logic [7:0] PIO_ADR_CUR_B     = 8'h2C;
    localparam logic [7:0] PIO_ADR_STATUS    = 8'h30;

    // Misc register bit positions
    localparam int PIO_BIT_CONN    = 0;
    localparam int PIO_BIT_BYPASS  = 1;
    localparam int PIO_BIT_RESTORE = 2;

    // Synchroniser depth
    localparam int PIO_SYNC_STAGES = 3;

    // ==========================================================
    // Ramp controller status carrier
    typedef struct packed {
        logic       switch_on;     // Level: start order active
        logic       switch_off;    // Pulse: general switch-off order
        logic       ramp_down;     // Level: decelerating
        logic       fault;         // Level: fault present
        logic [7:0] volt_pct;      // Output voltage in percent of rated
    } pio_ramp_type;

    // Analog source carrier
    typedef struct packed {
        logic [7:0] current;
        logic [7:0] voltage;
        logic [7:0] power_factor;
        logic [7:0] thermal;
    } pio_analog_type;

endpackage

// [hw/pio_in_sync.sv]
// Three-stage synchroniser with agreement filter for one field input
`timescale 1ns/10ps
module pio_in_sync
    import pio_pkg::*;
(
    input  wire logic clk_i,     // System clock
    input  wire logic rst_i,     // Synchronous reset
    input  wire logic pin_i,     // Raw field input
    output logic      level_o    // Filtered level
);

    logic [PIO_SYNC_STAGES-1:0] stage;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage <= '0;
        end else begin
            stage <= {stage[PIO_SYNC_STAGES-2:0], pin_i};
        end
    end

    // Accept a change once the last two stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
        end else if (stage[1] == stage[2]) begin
            level_o <= stage[2];
        end
    end

endmodule

// [hw/pio_function_select.sv]
// Function selection for relays, programmable inputs and analog monitor
`timescale 1ns/10ps
module pio_function_select
    import pio_pkg::*;
(
    input  wire logic           clk_i,          // 25 MHz clock
    input  wire logic           rst_i,          // Synchronous reset, high
    input  wire logic [7:0]     wb_adr_i,       // Wishbone byte address
    input  wire logic [31:0]    wb_dat_i,       // Wishbone write data
    output logic [31:0]         wb_dat_o,       // Wishbone read data
    input  wire logic           wb_we_i,        // Write enable
    input  wire logic [3:0]     wb_sel_i,       // Byte selects
    input  wire logic           wb_stb_i,       // Strobe
    input  wire logic           wb_cyc_i,       // Cycle
    output logic                wb_ack_o,       // Acknowledge
    input  wire pio_ramp_type   ramp_i,         // Ramp controller status
    input  wire pio_analog_type analog_i,       // Analog magnitudes
    input  wire logic [3:0]     din_i,          // Field inputs: start, two, three, four
    output logic                fault_relay_o,  // Fault relay coil
    output logic                relay_one_o,    // Relay one coil
    output logic                relay_two_o,    // Relay two coil
    output logic                error_reset_o,  // Pulse: clear error status
    output logic                ext_error_o,    // External error level
    output logic                fire_enable_o,  // Thyristor firing allowed
    output logic                emergency_o,    // Emergency stop latched
    output logic                start_cmd_o,    // Start command
    output logic                stop_cmd_o,     // Stop command
    output logic                reverse_o,      // Reversal requested
    output logic                jog_o,          // Jog active
    output logic [7:0]          jog_voltage_o,  // Jog voltage setting
    output logic [7:0]          analog_o,       // Analog monitor code
    output logic [9:0]          analog_gain_o   // Analog gain, hundredths
);

    // ==========================================================
    // Settings
    logic [2:0] fault_relay_function;
    logic [2:0] relay_one_function;
    logic [2:0] relay_two_function;
    logic [2:0] in_fn [1:3];          // Input two, three, four functions
    logic [2:0] analog_source_select;
    logic [9:0] analog_gain;
    logic [7:0] jog_voltage;
    logic [7:0] current_setting_a;
    logic [7:0] current_setting_b;
    logic       connection_type;
    logic       bypass_enable;
    logic       restore_defaults_setting;

    logic [3:0] din_s;
    logic [3:0] din_q;
    logic       wr;
    logic       rd;
    logic       r1_state;
    logic       r2_state;
    logic       three_wire;

    // ==========================================================
    // Input synchronisers
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            // R22 synchronise inputs
            pio_in_sync u_sync (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .pin_i   (din_i[g]),
                .level_o (din_s[g])
            );
        end
    endgenerate

    // Previous filtered level for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            din_q <= '0;
        end else begin
            din_q <= din_s;
        end
    end

    // ==========================================================
    // Wishbone slave, one wait-free cycle answer
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    assign rd = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // Acknowledge one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    // Setting registers and factory restore
    always_ff @(posedge clk_i) begin
        // R1 reload factory values, currents and connection kept
        if (rst_i || restore_defaults_setting) begin
            fault_relay_function     <= PIO_RST_FAULT_FN;
            relay_one_function       <= PIO_RST_RELAY1_FN;
            relay_two_function       <= PIO_RST_RELAY2_FN;
            in_fn[1]                 <= PIO_RST_IN2_FN;
            in_fn[2]                 <= PIO_RST_IN3_FN;
            in_fn[3]                 <= PIO_RST_IN4_FN;
            analog_source_select     <= PIO_RST_ANA_SEL;
            analog_gain              <= PIO_RST_ANA_GAIN;
            jog_voltage              <= PIO_RST_JOG;
            bypass_enable            <= 1'b0;
            restore_defaults_setting <= 1'b0;
            if (rst_i) begin
                current_setting_a    <= PIO_RST_CURRENT;
                current_setting_b    <= PIO_RST_CURRENT;
                connection_type      <= 1'b0;
            end
        end else if (wr) begin
            case (wb_adr_i)
                PIO_ADR_FAULT_FN: begin
                    if (wb_dat_i[2:0] == PIO_CODE_1 || wb_dat_i[2:0] == PIO_CODE_2) begin
                        fault_relay_function <= wb_dat_i[2:0];
                    end
                end
                // R20 relay codes 1 to 3 only
                PIO_ADR_RELAY1_FN: begin
                    if (wb_dat_i[2:0] != PIO_OFF && wb_dat_i[2:0] <= PIO_CODE_3) begin
                        relay_one_function <= wb_dat_i[2:0];
                    end
                end
                PIO_ADR_RELAY2_FN: begin
                    if (wb_dat_i[2:0] != PIO_OFF && wb_dat_i[2:0] <= PIO_CODE_3) begin
                        relay_two_function <= wb_dat_i[2:0];
                    end
                end
                // R15 inputs accept OFF to code 4
                PIO_ADR_IN2_FN, PIO_ADR_IN3_FN, PIO_ADR_IN4_FN: begin
                    if (wb_dat_i[2:0] <= PIO_CODE_4) begin
                        in_fn[wb_adr_i[4:2] - 3'h2] <= wb_dat_i[2:0];
                    end
                end
                PIO_ADR_ANA_SEL: begin
                    if (wb_dat_i[2:0] <= PIO_CODE_4) begin
                        analog_source_select <= wb_dat_i[2:0];
                    end
                end
                PIO_ADR_ANA_GAIN: begin
                    analog_gain <= wb_dat_i[9:0];
                end
                PIO_ADR_MISC: begin
                    connection_type          <= wb_dat_i[PIO_BIT_CONN];
                    bypass_enable            <= wb_dat_i[PIO_BIT_BYPASS];
                    restore_defaults_setting <= wb_dat_i[PIO_BIT_RESTORE];
                end
                PIO_ADR_JOG: begin
                    jog_voltage <= wb_dat_i[7:0];
                end
                PIO_ADR_CUR_A: begin
                    current_setting_a <= wb_dat_i[7:0];
                end
                PIO_ADR_CUR_B: begin
                    current_setting_b <= wb_dat_i[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data, registered with the acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (rd) begin
            case (wb_adr_i)
                PIO_ADR_FAULT_FN:  wb_dat_o <= {29'h0, fault_relay_function};
                PIO_ADR_RELAY1_FN: wb_dat_o <= {29'h0, relay_one_function};
                PIO_ADR_RELAY2_FN: wb_dat_o <= {29'h0, relay_two_function};
                PIO_ADR_IN2_FN:    wb_dat_o <= {29'h0, in_fn[1]};
                PIO_ADR_IN3_FN:    wb_dat_o <= {29'h0, in_fn[2]};
                PIO_ADR_IN4_FN:    wb_dat_o <= {29'h0, in_fn[3]};
                PIO_ADR_ANA_SEL:   wb_dat_o <= {29'h0, analog_source_select};
                PIO_ADR_ANA_GAIN:  wb_dat_o <= {22'h0, analog_gain};
                PIO_ADR_MISC: begin
                    wb_dat_o <= {29'h0, restore_defaults_setting, bypass_enable,
                                 connection_type};
                end
                PIO_ADR_JOG:       wb_dat_o <= {24'h0, jog_voltage};
                PIO_ADR_CUR_A:     wb_dat_o <= {24'h0, current_setting_a};
                PIO_ADR_CUR_B:     wb_dat_o <= {24'h0, current_setting_b};
                PIO_ADR_STATUS: begin
                    wb_dat_o <= {20'h0, din_s, emergency_o, ext_error_o,
                                 fire_enable_o, jog_o, reverse_o, fault_relay_o,
                                 relay_two_o, relay_one_o};
                end
                default:           wb_dat_o <= '0;
            endcase
        end
    end

    // ==========================================================
    // Relay function state machines
    // Operation / full-voltage mode latch for one relay
    function automatic logic relay_next(input logic [2:0] fn, input logic cur,
                                        input pio_ramp_type r);
        logic nxt;
        nxt = cur;
        if (fn == PIO_CODE_1) begin
            // R4 on at switch-on, off at switch-off or low ramp voltage
            if (r.switch_off || (r.ramp_down && r.volt_pct <= PIO_PCT_LOW)) begin
                nxt = 1'b0;
            end else if (r.switch_on && !r.ramp_down) begin
                nxt = 1'b1;
            end
        end else if (fn == PIO_CODE_2) begin
            // R5 on at full voltage, off at switch-off or ramp-down
            if (r.switch_off || r.ramp_down) begin
                nxt = 1'b0;
            end else if (r.switch_on && r.volt_pct >= PIO_PCT_FULL) begin
                nxt = 1'b1;
            end
        end else begin
            nxt = 1'b0;
        end
        return nxt;
    endfunction

    // Relay state latches
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r1_state <= 1'b0;
            r2_state <= 1'b0;
        end else begin
            r1_state <= relay_next(relay_one_function, r1_state, ramp_i);
            // R9 relay two codes 1-2 as relay one
            r2_state <= relay_next(relay_two_function, r2_state, ramp_i);
        end
    end

    // Relay coil drives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            relay_one_o   <= 1'b0;
            relay_two_o   <= 1'b0;
            fault_relay_o <= 1'b0;
        end else begin
            // R6 follow input three; R16 reversal
            relay_one_o <= (relay_one_function == PIO_CODE_3)
                         ? (din_s[2] && in_fn[2] == PIO_CODE_4 && !connection_type) : r1_state;
            // R9 DC brake on off command
            relay_two_o <= (relay_two_function == PIO_CODE_3)
                         ? (!ramp_i.switch_on && !connection_type) : r2_state;
            // R2 R3 fault relay polarity
            fault_relay_o <= (fault_relay_function == PIO_CODE_2) ? ramp_i.fault
                                                                   : !ramp_i.fault;
        end
    end

    // ==========================================================
    // Programmable input decoding
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            error_reset_o <= 1'b0;
            ext_error_o   <= 1'b0;
            fire_enable_o <= 1'b0;
        end else begin
            // R11 rising edge resets error
            error_reset_o <= ((in_fn[1] == PIO_CODE_1) && din_s[1] && !din_q[1])
                          || ((in_fn[2] == PIO_CODE_1) && din_s[2] && !din_q[2])
                          || ((in_fn[3] == PIO_CODE_1) && din_s[3] && !din_q[3]);
            // R12 open input raises error
            ext_error_o   <= ((in_fn[1] == PIO_CODE_2) && !din_s[1])
                          || ((in_fn[2] == PIO_CODE_2) && !din_s[2])
                          || ((in_fn[3] == PIO_CODE_2) && !din_s[3]);
            // R13 enable needs every enable input closed
            fire_enable_o <= !(((in_fn[1] == PIO_CODE_3) && !din_s[1])
                          ||   ((in_fn[2] == PIO_CODE_3) && !din_s[2])
                          ||   ((in_fn[3] == PIO_CODE_3) && !din_s[3]));
        end
    end

    // Emergency stop latch: first enable input to open
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            emergency_o <= 1'b0;
        end else if (!fire_enable_o) begin
            // R21 first opening enable stops
            emergency_o <= 1'b1;
        end else if (error_reset_o) begin
            emergency_o <= 1'b0;
        end
    end

    assign three_wire = (in_fn[1] == PIO_CODE_4);

    // Start, stop, reversal and jog commands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_cmd_o   <= 1'b0;
            stop_cmd_o    <= 1'b0;
            reverse_o     <= 1'b0;
            jog_o         <= 1'b0;
            jog_voltage_o <= PIO_RST_JOG;
        end else begin
            // R14 three-wire start and stop
            start_cmd_o   <= three_wire ? (din_s[0] && !din_q[0]) : din_s[0];
            stop_cmd_o    <= three_wire ? !din_s[1] : !din_s[0];
            reverse_o     <= (in_fn[2] == PIO_CODE_4) && din_s[2];
            // R17 jog while input four high
            jog_o         <= (in_fn[3] == PIO_CODE_4) && din_s[3];
            jog_voltage_o <= jog_voltage;
        end
    end

    // ==========================================================
    // Analog monitor source select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_o      <= 8'h00;
            analog_gain_o <= PIO_RST_ANA_GAIN;
        end else begin
            analog_gain_o <= analog_gain;
            // R18 R19 source select, OFF gives zero
            case (analog_source_select)
                PIO_CODE_1: analog_o <= analog_i.current;
                PIO_CODE_2: analog_o <= analog_i.voltage;
                PIO_CODE_3: analog_o <= analog_i.power_factor;
                PIO_CODE_4: analog_o <= analog_i.thermal;
                default:    analog_o <= 8'h00;
            endcase
        end
    end

endmodule

// [testbench/pio_function_select_asserts.sv]
// Port-level checker for the function select block
`timescale 1ns/10ps
module pio_function_select_asserts
    import pio_pkg::*;
(
    input wire logic        clk_i,          // Clock
    input wire logic        rst_i,          // Reset
    input wire logic        wb_cyc_i,       // Cycle
    input wire logic        wb_stb_i,       // Strobe
    input wire logic        wb_ack_o,       // Acknowledge
    input wire logic [31:0] wb_dat_o,       // Read data
    input wire logic        fire_enable_o,  // Firing allowed
    input wire logic        emergency_o,    // Emergency latch
    input wire logic        error_reset_o,  // Error clear pulse
    input wire logic        relay_one_o,    // Relay one coil
    input wire logic        relay_two_o,    // Relay two coil
    input wire logic [7:0]  jog_voltage_o,  // Jog setting
    input wire logic [7:0]  analog_o,       // Analog code
    input wire logic [9:0]  analog_gain_o   // Analog gain
);
    // ==========================================================
    // Bus handshake
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence ack_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_answer_a: assert property (req_s |=> ack_s) else $error("ack is not one pulse");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    rdata_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved without ack");
    // ==========================================================
    // Function outputs
    reset_value_a:
        assert property ($fell(rst_i) |-> analog_o == 8'h00 && analog_gain_o == PIO_RST_ANA_GAIN
            && !relay_one_o && !relay_two_o) else $error("wrong value after reset");
    emerg_set_a: assert property ($fell(fire_enable_o) |=> emergency_o)
        else $error("emergency not latched");
    emerg_clear_a:
        assert property ($fell(emergency_o) |-> error_reset_o || $past(error_reset_o))
            else $error("emergency cleared without error reset");
    err_pulse_a: assert property (error_reset_o |=> !error_reset_o)
        else $error("error reset longer than one cycle");
    setting_src_a:
        assert property ($changed(jog_voltage_o) || $changed(analog_gain_o)
            |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2))
            else $error("setting changed without a bus write");
endmodule
bind pio_function_select pio_function_select_asserts chk_u (.*);

// [testbench/pio_field_model.sv]
// Field switch and reversing contactor model
`timescale 1ns/10ps
module pio_field_model (
    input  wire logic       clk_i,        // Clock
    input  wire logic [3:0] close_i,      // Requested switch states
    input  wire logic       relay_one_i,  // Relay one coil
    output logic      [3:0] din_o = 4'h0, // Contacts at the inputs
    output logic            swap_o = 1'b0 // Phase-swap contactor closed
);
    // Contacts follow the requests, the contactor follows relay one, a cycle later
    always_ff @(posedge clk_i) begin
        din_o  <= close_i;
        swap_o <= relay_one_i;
    end
endmodule

// [testbench/tb_pio_function_select.sv]
// Self-checking bench for the function select block
`timescale 1ns/10ps
module tb_pio_function_select;
    import pio_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_stb_i = 0, wb_cyc_i = 0, wb_ack_o, swap;
    logic fault_relay_o, relay_one_o, relay_two_o, error_reset_o, ext_error_o, fire_enable_o;
    logic emergency_o, start_cmd_o, stop_cmd_o, reverse_o, jog_o;
    logic [7:0]     wb_adr_i = 8'h00, jog_voltage_o, analog_o;
    logic [31:0]    wb_dat_i = 32'h0, wb_dat_o, q;
    logic [3:0]     wb_sel_i = 4'hF, din_i, sw = 4'h0;
    logic [9:0]     analog_gain_o;
    pio_ramp_type   ramp_i = '0;
    pio_analog_type analog_i = '{8'h11, 8'h22, 8'h33, 8'h44};
    int n_mismatch = 0, total_checks = 0, n_er = 0, n_st = 0, m;
    logic [7:0] adr_t [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h3C, 8'h24};
    logic [7:0] def_t [9] = '{8'h01, 8'h01, 8'h02, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
    pio_function_select dut_u (.*);
    pio_field_model fm_u (.clk_i(clk_i), .close_i(sw), .relay_one_i(relay_one_o), .din_o(din_i),
        .swap_o(swap));
    // Clock and pulse counters
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        n_er += (error_reset_o === 1'b1);
        n_st += (start_cmd_o === 1'b1);
    end
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One classic Wishbone cycle; read data lands in q
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1;
        wb_stb_i <= 1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 0;
        wb_stb_i <= 0;
        if (n >= 50) begin
            n_mismatch++;
            finish_test();
        end
    endtask
    task settle;
        repeat (10) @(posedge clk_i);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        for (int i = 0; i < 9; i++) begin
            wb(adr_t[i], 0, 0);
            chk("factory value", {24'h0, def_t[i]}, q);
        end
        chk("analog off", {14'h0, PIO_RST_ANA_GAIN, 8'h00}, {14'h0, analog_gain_o, analog_o});
        $display("test defaults done");
        settle();
        chk("fault relay no fault", 1, fault_relay_o);
        ramp_i.fault <= 1;
        settle();
        chk("fault relay fault", 0, fault_relay_o);
        wb(PIO_ADR_FAULT_FN, 1, 2);
        wb(PIO_ADR_FAULT_FN, 1, 3);
        settle();
        chk("fault relay code two", 1, fault_relay_o);
        $display("test fault relay done");
        wb(PIO_ADR_MISC, 1, 32'h2);
        ramp_i.switch_on <= 1;
        ramp_i.volt_pct <= 8'h63;
        settle();
        chk("relay one on", 1, relay_one_o);
        chk("relay two below full", 0, relay_two_o);
        ramp_i.volt_pct <= 8'h64;
        settle();
        chk("relay two full", 1, relay_two_o);
        ramp_i.ramp_down <= 1;
        ramp_i.volt_pct <= 8'h1F;
        settle();
        chk("relay one above low", 1, relay_one_o);
        chk("relay two ramp down", 0, relay_two_o);
        ramp_i.volt_pct <= 8'h1E;
        settle();
        chk("relay one at low", 0, relay_one_o);
        wb(PIO_ADR_RELAY2_FN, 1, 3);
        ramp_i <= '0;
        settle();
        chk("brake relay", 1, relay_two_o);
        $display("test relays done");
        wb(PIO_ADR_IN3_FN, 1, 4);
        wb(PIO_ADR_RELAY1_FN, 1, 3);
        sw <= 4'h4;
        settle();
        chk("reverse relay", 3, {relay_one_o, reverse_o});
        chk("phase swap", 1, swap);
        sw <= 4'h0;
        settle();
        chk("forward relay", 0, {relay_one_o, reverse_o});
        for (int i = 1; i < 5; i++) begin
            wb(PIO_ADR_ANA_SEL, 1, i);
            settle();
            chk("analog source", 8'h11 * i, analog_o);
        end
        wb(PIO_ADR_JOG, 1, 8'h5A);
        wb(PIO_ADR_IN4_FN, 1, 4);
        sw <= 4'h8;
        settle();
        chk("jog", 9'h15A, {jog_o, jog_voltage_o});
        $display("test outputs done");
        wb(PIO_ADR_IN2_FN, 1, 2);
        sw <= 4'h0;
        settle();
        chk("external error open", 1, ext_error_o);
        wb(PIO_ADR_IN2_FN, 1, 3);
        sw <= 4'h2;
        settle();
        chk("no external error", 2'h1, {ext_error_o, fire_enable_o});
        sw <= 4'h0;
        settle();
        chk("enable open", 2'h1, {fire_enable_o, emergency_o});
        wb(PIO_ADR_IN3_FN, 1, 1);
        sw <= 4'h2;
        settle();
        m = n_er;
        sw <= 4'h6;
        settle();
        chk("error reset pulses", 1, n_er - m);
        chk("emergency cleared", 0, emergency_o);
        wb(PIO_ADR_IN2_FN, 1, 4);
        settle();
        m = n_st;
        sw <= 4'h3;
        settle();
        chk("start pulses", 1, n_st - m);
        chk("stop held", 0, stop_cmd_o);
        sw <= 4'h1;
        settle();
        chk("stop", 1, stop_cmd_o);
        $display("test inputs done");
        wb(PIO_ADR_CUR_A, 1, 8'h77);
        wb(PIO_ADR_MISC, 1, 32'h1);
        wb(PIO_ADR_MISC, 1, 32'h5);
        adr_t = '{8'h24, 8'h28, 8'h20, 8'h0C, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18};
        def_t = '{8'h00, 8'h77, 8'h01, 8'h01, 8'h01, 8'h02, 8'h02, 8'h00, 8'h00};
        for (int i = 0; i < 9; i++) begin
            wb(adr_t[i], 0, 0);
            chk("after restore", {24'h0, def_t[i]}, q);
        end
        $display("test restore done");
        finish_test();
    end
endmodule
